// File: rtl/bpm_pkg.sv
// Package: register selectors, field positions and reset values of the debug set
package bpm_pkg;

    localparam int NUM_BP = 6;
    localparam int NUM_WP = 4;

    // Register selector codes on the system-register move port
    localparam logic [7:0] SEL_BP_VALUE = 8'h00;
    localparam logic [7:0] SEL_BP_CTRL = 8'h10;
    localparam logic [7:0] SEL_WP_VALUE = 8'h20;
    localparam logic [7:0] SEL_WP_CTRL = 8'h30;
    localparam logic [7:0] SEL_EXT_RX = 8'h40;
    localparam logic [7:0] SEL_EXT_TX = 8'h41;
    localparam logic [7:0] SEL_IRQ_EN = 8'h42;
    localparam logic [7:0] SEL_MON_CTRL = 8'h43;
    localparam logic [7:0] SEL_LOCK_CATCH = 8'h44;
    localparam logic [7:0] SEL_COMMS_STAT = 8'h45;
    localparam logic [7:0] SEL_HALF_DUPLEX = 8'h46;
    localparam logic [7:0] SEL_INT_TX = 8'h47;
    localparam logic [7:0] SEL_INT_RX = 8'h48;
    localparam logic [7:0] SEL_ROM_PTR = 8'h49;
    localparam logic [7:0] SEL_LOCK_ACCESS = 8'h4a;
    localparam logic [7:0] SEL_LOCK_STATUS = 8'h4b;
    localparam logic [7:0] SEL_DOUBLE_LOCK = 8'h4c;
    localparam logic [7:0] SEL_PWR_RST = 8'h4d;
    localparam logic [7:0] SEL_CLAIM_SET = 8'h4e;
    localparam logic [7:0] SEL_CLAIM_CLR = 8'h4f;
    localparam logic [7:0] SEL_AUTH_STATUS = 8'h50;

    // Breakpoint control field positions
    localparam int BT_HI = 23;
    localparam int BT_LO = 20;
    localparam int BT_LINK = 20;
    localparam int LBN_HI = 19;
    localparam int LBN_LO = 16;
    localparam int SSC_HI = 15;
    localparam int SSC_LO = 14;
    localparam int HMC_BIT = 13;
    localparam int BAS_HI = 8;
    localparam int BAS_LO = 5;
    localparam int PMC_HI = 2;
    localparam int PMC_LO = 1;
    localparam int EN_BIT = 0;

    // Writable bits of a breakpoint control word; the rest read as zero
    localparam logic [31:0] BP_CTRL_WMASK = 32'h00ffe1e7;
    // Same, with the base-type bits held at zero
    localparam logic [31:0] BP_CTRL_WMASK_NOCTX = 32'h001fe1e7;

    // Base types
    localparam logic [2:0] BT_ADDR = 3'h0;
    localparam logic [2:0] BT_CTX = 3'h1;
    localparam logic [2:0] BT_MISMATCH = 3'h2;
    localparam logic [2:0] BT_CTX1 = 3'h3;
    localparam logic [2:0] BT_VMID = 3'h4;
    localparam logic [2:0] BT_VMID_CTX1 = 3'h5;
    localparam logic [2:0] BT_CTX2 = 3'h6;
    localparam logic [2:0] BT_CTX_FULL = 3'h7;

    // Byte lane select codes
    localparam logic [3:0] BAS_LOW_HALF = 4'h3;
    localparam logic [3:0] BAS_HIGH_HALF = 4'hc;
    localparam logic [3:0] BAS_FULL = 4'hf;

    // Reset and fixed values
    localparam logic [31:0] RST_ZERO = 32'h00000000;
    localparam logic [31:0] CLAIM_SET_READ = 32'h000000ff;
    localparam logic [31:0] AUTH_STATUS_VAL = 32'h000000aa;
    localparam int LOCK_BIT = 1;
    localparam logic [31:0] LOCK_STATUS_FIXED = 32'h00000008;
    localparam int RXFULL_BIT = 30;
    localparam int TXFULL_BIT = 29;

endpackage : bpm_pkg

// File: rtl/bpm_pair.sv
// One breakpoint pair: type decode, value compare and state qualification
`timescale 1ns/1ps
`default_nettype none
module bpm_pair (
    input wire logic [31:0] ctrl,
    input wire logic [63:0] value,
    input wire logic [63:0] fetch_pc,
    input wire logic [31:0] first_level_context_id,
    input wire logic [31:0] second_level_context_id,
    input wire logic [15:0] vmid,
    input wire logic nonsecure,
    input wire logic [1:0] exc_level,
    input wire logic wide_regime,
    input wire logic halt_allowed,
    output logic addr_hit,
    output logic ctx_hit,
    output logic qual_ok
);
    logic [2:0] base;
    logic [3:0] lanes;
    logic [1:0] security_state_select;
    logic lane_ok;
    logic addr_eq;
    logic c1_eq;
    logic c2_eq;
    logic vm_eq;
    logic ssc_ok;

    assign base = ctrl[bpm_pkg::BT_HI:bpm_pkg::BT_LO + 1];
    assign lanes = ctrl[bpm_pkg::BAS_HI:bpm_pkg::BAS_LO];
    assign security_state_select = ctrl[bpm_pkg::SSC_HI:bpm_pkg::SSC_LO];
    assign c1_eq = value[31:0] == first_level_context_id;
    assign c2_eq = value[63:32] == second_level_context_id;
    assign vm_eq = value[47:32] == vmid;
    assign addr_eq = (fetch_pc[63:2] == value[63:2]) && lane_ok;

    always_comb
    begin
        // Reserved lane codes never match
        unique case (lanes)
            bpm_pkg::BAS_FULL: lane_ok = 1'b1;
            bpm_pkg::BAS_LOW_HALF: lane_ok = !fetch_pc[1];
            bpm_pkg::BAS_HIGH_HALF: lane_ok = fetch_pc[1];
            default: lane_ok = 1'b0;
        endcase
    end

    always_comb
    begin
        addr_hit = 1'b0;
        ctx_hit = 1'b0;
        unique case (base)
            // R03 address compare
            bpm_pkg::BT_ADDR: addr_hit = addr_eq;
            // R05 mismatch or plain match
            bpm_pkg::BT_MISMATCH:
                addr_hit = (wide_regime || halt_allowed) ? addr_eq : !addr_eq;
            // R04 first-level context
            bpm_pkg::BT_CTX, bpm_pkg::BT_CTX1: ctx_hit = c1_eq;
            // R06 vmid compare
            bpm_pkg::BT_VMID: ctx_hit = vm_eq;
            // R07 vmid and context
            bpm_pkg::BT_VMID_CTX1: ctx_hit = c1_eq && vm_eq;
            // R08 second-level and full
            bpm_pkg::BT_CTX2: ctx_hit = c2_eq;
            bpm_pkg::BT_CTX_FULL: ctx_hit = c1_eq && c2_eq;
        endcase
    end

    always_comb
    begin
        unique case (security_state_select)
            2'b00: ssc_ok = 1'b1;
            2'b10: ssc_ok = !nonsecure;
            default: ssc_ok = nonsecure;
        endcase
    end

    always_comb
    begin
        // R11 state qualification
        unique case (exc_level)
            2'd0: qual_ok = ssc_ok && ctrl[bpm_pkg::PMC_HI];
            2'd1: qual_ok = ssc_ok && ctrl[bpm_pkg::PMC_LO];
            // R12 privilege ignored in hyp
            2'd2: qual_ok = ssc_ok && ctrl[bpm_pkg::HMC_BIT];
            default: qual_ok = ctrl[bpm_pkg::HMC_BIT] && (security_state_select == 2'b10);
        endcase
    end
endmodule : bpm_pair
`default_nettype wire

// File: rtl/bpm_top.sv
// Debug register set with six breakpoint pairs and the event logic
// How it works
// R01 - Six breakpoint pairs, each a 64-bit value and 32-bit control word.
// R02 - Type field bits 23:20: upper three base type, lowest enables linking.
// R03 - Base type 000 compares the value with the fetched instruction address.
// R04 - Base types 001 and 011 compare value low word with first context.
// R05 - Type 010 is mismatch, or plain match in wide regime or halting.
// R06 - Type 100 compares value bits 47:32 with the vmid.
// R07 - Type 101 needs both first context and vmid to match.
// R08 - Type 110 compares high word with second context; 111 needs both.
// R09 - Pairs without context support hold base type bits at zero.
// R10 - Linked index bits 19:16 name the context pair qualifying this one.
// R11 - Security, higher-mode and privilege fields decide where events fire.
// R12 - Privilege bits are ignored while executing in hypervisor level.
// R13 - Debugger programs byte lanes only as 3, C or F.
// R14 - Enable bit 0; a disabled pair never raises an event.
// R15 - Debugger writes every enable bit before turning debug on.
// R16 - Four watchpoint pairs, 64-bit value and 32-bit control, read-write.
// R17 - Lock status is read-only, resets to 0000000A.
// R18 - Authentication status is read-only and reads 000000AA.
// R19 - Claim set resets to FF, claim clear to zero, both read-write.
// R20 - Comms status read-only zero at reset; comms irq enable resets zero.
// R21 - Half-duplex 64-bit, transmit write-only, receive read-only, reset zero.
// R22 - Debug ROM pointer is reserved, read-only, always zero.
// R23 - Writing ones to claim set bits 7:0 sets them; zeros do nothing.
// R24 - Registers reached by register moves from core or external debugger.
// R25 - Event needs enable, type match, linked context match and qualifiers.
// R26 - Reserved control bits read zero and ignore writes. Only breakpoint control is masked; watchpoint control stores all 32 bits.
`timescale 1ns/1ps
`default_nettype none
module bpm_top #(
    parameter int NUM_BP = bpm_pkg::NUM_BP,
    parameter int NUM_WP = bpm_pkg::NUM_WP,
    // Pairs able to match context; others keep base type zero
    parameter logic [5:0] CTX_AWARE = 6'h30
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] reg_sel,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [63:0] reg_wdata,
    output logic [63:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic fetch_valid,
    input wire logic [63:0] fetch_pc,
    input wire logic [31:0] first_level_context_id,
    input wire logic [31:0] second_level_context_id,
    input wire logic [15:0] vmid,
    input wire logic nonsecure,
    input wire logic [1:0] exc_level,
    input wire logic wide_regime,
    input wire logic halt_allowed,
    output logic bkpt_event,
    output logic [5:0] bkpt_hit
);

    ////////////////////////////////////////////////////////////////////////
    // Storage

    logic [63:0] bp_value_reg [NUM_BP];
    logic [31:0] bp_ctrl_reg [NUM_BP];
    logic [63:0] wp_value_reg [NUM_WP];
    logic [31:0] wp_ctrl_reg [NUM_WP];
    logic [31:0] ext_rx_reg;
    logic [31:0] tx_reg;
    logic [31:0] rx_reg;
    logic txfull_reg;
    logic rxfull_reg;
    logic [31:0] irq_en_reg;
    logic [31:0] mon_ctrl_reg;
    logic [31:0] lock_catch_reg;
    logic lock_reg;
    logic [31:0] double_lock_reg;
    logic [31:0] pwr_rst_reg;
    logic [7:0] claim_reg;
    logic [63:0] rdata_next;
    logic [5:0] hit_next;
    logic [NUM_BP-1:0] addr_hit;
    logic [NUM_BP-1:0] ctx_hit;
    logic [NUM_BP-1:0] qual_ok;
    logic [NUM_BP-1:0] is_ctx;
    logic [31:0] comms_status;
    logic [31:0] lock_status;

    assign comms_status = {1'b0, rxfull_reg, txfull_reg, 29'h0};
    assign lock_status = bpm_pkg::LOCK_STATUS_FIXED
        | {30'h0, lock_reg, 1'b0};

    ////////////////////////////////////////////////////////////////////////
    // Breakpoint registers

    // R01 six pairs of value and control
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < NUM_BP; i++)
            begin
                bp_value_reg[i] <= 64'h0;
                // R15 known enable after reset
                bp_ctrl_reg[i] <= bpm_pkg::RST_ZERO;
            end
        end
        else if (reg_wr)
        begin
            for (int i = 0; i < NUM_BP; i++)
            begin
                if (reg_sel == bpm_pkg::SEL_BP_VALUE + 8'(i))
                    bp_value_reg[i] <= reg_wdata;
                // R26 reserved bits masked
                if (reg_sel == bpm_pkg::SEL_BP_CTRL + 8'(i))
                    // R09 base type zero without context support
                    bp_ctrl_reg[i] <= reg_wdata[31:0] & (CTX_AWARE[i]
                        ? bpm_pkg::BP_CTRL_WMASK
                        : bpm_pkg::BP_CTRL_WMASK_NOCTX);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchpoint registers, stored only

    // R16 four watchpoint pairs
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < NUM_WP; i++)
            begin
                wp_value_reg[i] <= 64'h0;
                wp_ctrl_reg[i] <= bpm_pkg::RST_ZERO;
            end
        end
        else if (reg_wr)
        begin
            for (int i = 0; i < NUM_WP; i++)
            begin
                if (reg_sel == bpm_pkg::SEL_WP_VALUE + 8'(i))
                    wp_value_reg[i] <= reg_wdata;
                if (reg_sel == bpm_pkg::SEL_WP_CTRL + 8'(i))
                    wp_ctrl_reg[i] <= reg_wdata[31:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Comms channel

    // R21 transfer registers and full flags
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_reg <= bpm_pkg::RST_ZERO;
            rx_reg <= bpm_pkg::RST_ZERO;
            ext_rx_reg <= bpm_pkg::RST_ZERO;
            txfull_reg <= 1'b0;
            rxfull_reg <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_sel == bpm_pkg::SEL_INT_TX)
            begin
                tx_reg <= reg_wdata[31:0];
                txfull_reg <= 1'b1;
            end
            else if (reg_wr && reg_sel == bpm_pkg::SEL_HALF_DUPLEX)
            begin
                tx_reg <= reg_wdata[31:0];
                rx_reg <= reg_wdata[63:32];
                txfull_reg <= 1'b1;
            end
            else if (reg_rd && reg_sel == bpm_pkg::SEL_EXT_TX)
                txfull_reg <= 1'b0;
            // Receive side filled from the external view
            if (reg_wr && reg_sel == bpm_pkg::SEL_EXT_RX)
            begin
                ext_rx_reg <= reg_wdata[31:0];
                rx_reg <= reg_wdata[31:0];
                rxfull_reg <= 1'b1;
            end
            else if (reg_rd && (reg_sel == bpm_pkg::SEL_INT_RX
                || reg_sel == bpm_pkg::SEL_HALF_DUPLEX))
                rxfull_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control, lock and claim registers

    // R20 irq enable resets zero
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_en_reg <= bpm_pkg::RST_ZERO;
            mon_ctrl_reg <= bpm_pkg::RST_ZERO;
            lock_catch_reg <= bpm_pkg::RST_ZERO;
            double_lock_reg <= bpm_pkg::RST_ZERO;
            pwr_rst_reg <= bpm_pkg::RST_ZERO;
        end
        else if (reg_wr)
        begin
            unique case (reg_sel)
                bpm_pkg::SEL_IRQ_EN: irq_en_reg <= reg_wdata[31:0];
                bpm_pkg::SEL_MON_CTRL: mon_ctrl_reg <= reg_wdata[31:0];
                bpm_pkg::SEL_LOCK_CATCH: lock_catch_reg <= reg_wdata[31:0];
                bpm_pkg::SEL_DOUBLE_LOCK: double_lock_reg <= reg_wdata[31:0];
                bpm_pkg::SEL_PWR_RST: pwr_rst_reg <= reg_wdata[31:0];
                default: ;
            endcase
        end
    end

    // R17 lock set at reset, lock access writes it
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            lock_reg <= 1'b1;
        else if (reg_wr && reg_sel == bpm_pkg::SEL_LOCK_ACCESS)
            lock_reg <= reg_wdata[0];
    end

    // Claim bits live in one register; set and clear are two views
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            claim_reg <= 8'h00;
        // R23 ones set, zeros leave
        else if (reg_wr && reg_sel == bpm_pkg::SEL_CLAIM_SET)
            claim_reg <= claim_reg | reg_wdata[7:0];
        else if (reg_wr && reg_sel == bpm_pkg::SEL_CLAIM_CLR)
            claim_reg <= claim_reg & ~reg_wdata[7:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    always_comb
    begin
        rdata_next = 64'h0;
        for (int i = 0; i < NUM_BP; i++)
        begin
            if (reg_sel == bpm_pkg::SEL_BP_VALUE + 8'(i))
                rdata_next = bp_value_reg[i];
            if (reg_sel == bpm_pkg::SEL_BP_CTRL + 8'(i))
                rdata_next = {32'h0, bp_ctrl_reg[i]};
        end
        for (int i = 0; i < NUM_WP; i++)
        begin
            if (reg_sel == bpm_pkg::SEL_WP_VALUE + 8'(i))
                rdata_next = wp_value_reg[i];
            if (reg_sel == bpm_pkg::SEL_WP_CTRL + 8'(i))
                rdata_next = {32'h0, wp_ctrl_reg[i]};
        end
        unique case (reg_sel)
            bpm_pkg::SEL_EXT_RX: rdata_next = {32'h0, ext_rx_reg};
            bpm_pkg::SEL_EXT_TX: rdata_next = {32'h0, tx_reg};
            bpm_pkg::SEL_IRQ_EN: rdata_next = {32'h0, irq_en_reg};
            bpm_pkg::SEL_MON_CTRL: rdata_next = {32'h0, mon_ctrl_reg};
            bpm_pkg::SEL_LOCK_CATCH: rdata_next = {32'h0, lock_catch_reg};
            // R20 status read-only
            bpm_pkg::SEL_COMMS_STAT: rdata_next = {32'h0, comms_status};
            bpm_pkg::SEL_HALF_DUPLEX: rdata_next = {rx_reg, tx_reg};
            bpm_pkg::SEL_INT_RX: rdata_next = {32'h0, rx_reg};
            // R17 lock status view
            bpm_pkg::SEL_LOCK_STATUS: rdata_next = {32'h0, lock_status};
            bpm_pkg::SEL_DOUBLE_LOCK: rdata_next = {32'h0, double_lock_reg};
            bpm_pkg::SEL_PWR_RST: rdata_next = {32'h0, pwr_rst_reg};
            // R19 set view shows implemented bits
            bpm_pkg::SEL_CLAIM_SET:
                rdata_next = {32'h0, bpm_pkg::CLAIM_SET_READ};
            bpm_pkg::SEL_CLAIM_CLR: rdata_next = {56'h0, claim_reg};
            // R18 fixed authentication status
            bpm_pkg::SEL_AUTH_STATUS:
                rdata_next = {32'h0, bpm_pkg::AUTH_STATUS_VAL};
            // R22 rom pointer reads zero; write-only views read zero
            default: ;
        endcase
    end

    // R24 register move access, answered one cycle later
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata <= 64'h0;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Match logic

    for (genvar g = 0; g < NUM_BP; g++)
    begin : g_pair
        bpm_pair u_pair (
            .ctrl(bp_ctrl_reg[g]),
            .value(bp_value_reg[g]),
            .fetch_pc(fetch_pc),
            .first_level_context_id(first_level_context_id),
            .second_level_context_id(second_level_context_id),
            .vmid(vmid),
            .nonsecure(nonsecure),
            .exc_level(exc_level),
            .wide_regime(wide_regime),
            .halt_allowed(halt_allowed),
            .addr_hit(addr_hit[g]),
            .ctx_hit(ctx_hit[g]),
            .qual_ok(qual_ok[g])
        );
        // R02 base type selects context compare
        assign is_ctx[g] = bp_ctrl_reg[g][bpm_pkg::BT_HI:bpm_pkg::BT_LO + 1]
            != bpm_pkg::BT_ADDR
            && bp_ctrl_reg[g][bpm_pkg::BT_HI:bpm_pkg::BT_LO + 1]
            != bpm_pkg::BT_MISMATCH;
    end

    always_comb
    begin
        logic [3:0] linked_index;
        logic linked;
        logic link_ok;
        hit_next = 6'h0;
        linked_index = 4'h0;
        linked = 1'b0;
        link_ok = 1'b0;
        for (int i = 0; i < NUM_BP; i++)
        begin
            linked_index = bp_ctrl_reg[i][bpm_pkg::LBN_HI:bpm_pkg::LBN_LO];
            linked = bp_ctrl_reg[i][bpm_pkg::BT_LINK];
            // R10 linked context pair must be enabled and matching
            link_ok = 1'b0;
            for (int j = 0; j < NUM_BP; j++)
                if (linked_index == 4'(j))
                    link_ok = is_ctx[j] && ctx_hit[j]
                        && bp_ctrl_reg[j][bpm_pkg::EN_BIT];
            // R14 disabled pair never fires
            // R25 enable, match, link and qualifiers together
            hit_next[i] = fetch_valid && bp_ctrl_reg[i][bpm_pkg::EN_BIT]
                && qual_ok[i]
                && ((addr_hit[i] && (!linked || link_ok))
                || (ctx_hit[i] && !linked));
        end
    end

    // Event registered so the outputs come from flops
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            bkpt_hit <= 6'h0;
            bkpt_event <= 1'b0;
        end
        else
        begin
            bkpt_hit <= hit_next;
            bkpt_event <= |hit_next;
        end
    end

endmodule : bpm_top
`default_nettype wire

// File: tb/bpm_checker.sv
// Checker for register answers and breakpoint event timing
`timescale 1ns/1ps
`default_nettype none
module bpm_checker (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] reg_sel,
    input wire logic reg_rd,
    input wire logic [63:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic fetch_valid,
    input wire logic bkpt_event,
    input wire logic [5:0] bkpt_hit
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    property p_ans;
        reg_rd |=> reg_rvalid;
    endproperty
    a_ans: assert property (p_ans) else $error("read unanswered");
    property p_quiet;
        !reg_rd |=> !reg_rvalid;
    endproperty
    a_quiet: assert property (p_quiet) else $error("stray answer");
    property p_hold;
        !reg_rvalid |-> $stable(reg_rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_auth;
        reg_rd && reg_sel == 8'h50 |=> reg_rdata == 64'haa;
    endproperty
    a_auth: assert property (p_auth) else $error("auth value");
    property p_rom;
        reg_rd && reg_sel == 8'h49 |=> reg_rdata == 64'h0;
    endproperty
    a_rom: assert property (p_rom) else $error("rom pointer");
    property p_claim;
        reg_rd && reg_sel == 8'h4e |=> reg_rdata == 64'hff;
    endproperty
    a_claim: assert property (p_claim) else $error("claim set view");
    property p_evt;
        bkpt_event == (|bkpt_hit);
    endproperty
    a_evt: assert property (p_evt) else $error("event vs hits");
    property p_idle;
        !fetch_valid |=> bkpt_hit == 6'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("hit without fetch");
endmodule : bpm_checker
bind bpm_top bpm_checker u_chk (.clock(clock), .resetn(resetn),
    .reg_sel(reg_sel), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .fetch_valid(fetch_valid),
    .bkpt_event(bkpt_event), .bkpt_hit(bkpt_hit));
`default_nettype wire

// File: tb/bpm_host.sv
// Debugger host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module bpm_host (
    input wire logic clock,
    output logic [7:0] reg_sel,
    output logic reg_wr,
    output logic reg_rd,
    output logic [63:0] reg_wdata,
    input wire logic [63:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial
    begin
        reg_sel = 8'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 64'h0;
    end
    task automatic wr(input logic [7:0] sel, input logic [63:0] d);
        @(posedge clock);
        reg_sel <= sel;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        // Released data is scrambled so a stale value cannot pass
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] sel, output logic [63:0] d);
        @(posedge clock);
        reg_sel <= sel;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        d = reg_rvalid ? reg_rdata : ~reg_rdata;
    endtask : rd
    task automatic clear_enables;
        for (int i = 0; i < 6; i++)
            wr(8'h10 + 8'(i), 64'h0);
    endtask : clear_enables
endmodule : bpm_host
`default_nettype wire

// File: tb/bpm_top_test.sv
// Self-checking bench for the breakpoint debug register set
`timescale 1ns/1ps
`default_nettype none
module bpm_top_test;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_sel;
    logic reg_wr;
    logic reg_rd;
    logic reg_rvalid;
    logic fetch_valid = 1'b0;
    logic bkpt_event;
    logic [63:0] reg_wdata;
    logic [63:0] reg_rdata;
    logic [63:0] fetch_pc = 64'h0;
    logic [63:0] got;
    logic [31:0] ctx1 = 32'h1234;
    logic [31:0] ctx2 = 32'hab;
    logic [15:0] vmid = 16'hab;
    logic [1:0] exc_level = 2'h1;
    logic nsec = 1'b0;
    logic wide = 1'b1;
    logic halt = 1'b0;
    logic [5:0] bkpt_hit;
    int err_total = 0;
    int n_checks = 0;
    always #10 clock = ~clock;
    bpm_top dut (.clock(clock), .resetn(resetn), .reg_sel(reg_sel),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .fetch_valid(fetch_valid), .fetch_pc(fetch_pc),
        .first_level_context_id(ctx1), .second_level_context_id(ctx2),
        .vmid(vmid), .nonsecure(nsec), .exc_level(exc_level),
        .wide_regime(wide), .halt_allowed(halt),
        .bkpt_event(bkpt_event), .bkpt_hit(bkpt_hit));
    bpm_host host (.clock(clock), .reg_sel(reg_sel), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] seen, input logic [63:0] want);
        n_checks++;
        if (seen !== want)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] sel, input logic [63:0] want);
        host.rd(sel, got);
        chk(got, want);
    endtask : rchk
    // One fetch, hits show one cycle later
    task automatic m(input logic [7:0] n, input logic [31:0] c,
        input logic [63:0] pc, input logic [1:0] el, input logic [5:0] w);
        host.wr(8'h10 + n, {32'h0, c});
        @(posedge clock);
        fetch_valid <= 1'b1;
        fetch_pc <= pc;
        exc_level <= el;
        @(posedge clock);
        fetch_valid <= 1'b0;
        @(negedge clock);
        chk({58'h0, bkpt_hit}, {58'h0, w});
        chk({63'h0, bkpt_event}, {63'h0, |w});
        host.wr(8'h10 + n, 64'h0);
    endtask : m
    task automatic t_regs;
        logic [7:0] s [12] = '{8'h4b, 8'h50, 8'h49, 8'h45, 8'h48, 8'h4e,
            8'h4f, 8'h42, 8'h46, 8'h44, 8'h4c, 8'h7f};
        for (int p = 0; p < 2; p++)
        begin
            for (int i = 0; i < 12; i++)
                rchk(s[i], i == 0 ? 64'ha : i == 1 ? 64'haa :
                    i == 5 ? 64'hff : 64'h0);
            for (int i = 0; i < 5; i++)
                host.wr(s[i], '1);
        end
    endtask : t_regs
    task automatic t_mask;
        host.wr(8'h10, '1);
        rchk(8'h10, 64'h001fe1e7);
        host.wr(8'h14, '1);
        rchk(8'h14, 64'h00ffe1e7);
        host.wr(8'h05, 64'h0123456789abcdef);
        rchk(8'h05, 64'h0123456789abcdef);
        host.wr(8'h23, 64'hfedcba9876543210);
        rchk(8'h23, 64'hfedcba9876543210);
        host.wr(8'h47, 64'h5a);
        rchk(8'h45, 64'h20000000);
        rchk(8'h41, 64'h5a);
        rchk(8'h45, 64'h0);
        host.clear_enables;
        host.wr(8'h4e, 64'h05);
        host.wr(8'h4e, 64'h30);
        rchk(8'h4f, 64'h35);
        host.wr(8'h4f, 64'h01);
        rchk(8'h4f, 64'h34);
    endtask : t_mask
    task automatic t_addr;
        host.wr(8'h00, 64'h1000);
        m(0, 32'h1e7, 64'h1000, 2'h1, 6'h01);
        m(0, 32'h1e7, 64'h1004, 2'h1, 6'h00);
        m(0, 32'h1e6, 64'h1000, 2'h1, 6'h00);
        m(0, 32'h067, 64'h1000, 2'h1, 6'h01);
        m(0, 32'h067, 64'h1002, 2'h1, 6'h00);
        m(0, 32'h187, 64'h1002, 2'h1, 6'h01);
        m(0, 32'h1e3, 64'h1000, 2'h0, 6'h00);
        m(0, 32'h1e5, 64'h1000, 2'h0, 6'h01);
        m(0, 32'h1e7, 64'h1000, 2'h2, 6'h00);
        m(0, 32'h21e1, 64'h1000, 2'h2, 6'h01);
        m(0, 32'h81e7, 64'h1000, 2'h1, 6'h01);
        m(0, 32'h41e7, 64'h1000, 2'h1, 6'h00);
        nsec <= 1'b1;
        m(0, 32'h41e7, 64'h1000, 2'h1, 6'h01);
        nsec <= 1'b0;
    endtask : t_addr
    task automatic t_ctx;
        logic [2:0] ty [6] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
        host.wr(8'h04, 64'h000000ab_00001234);
        for (int p = 0; p < 2; p++)
        begin
            ctx1 <= p == 0 ? 32'h1234 : 32'h0;
            for (int i = 0; i < 6; i++)
                m(4, {8'h0, ty[i], 21'h1e7}, 64'h0, 2'h1,
                    p == 0 || !ty[i][0] ? 6'h10 : 6'h0);
        end
        ctx1 <= 32'h1234;
        m(4, 32'h4001e7, 64'h000000ab_00001234, 2'h1, 6'h10);
        m(4, 32'h4001e7, 64'h000000ab_00001238, 2'h1, 6'h00);
        wide <= 1'b0;
        m(4, 32'h4001e7, 64'h000000ab_00001238, 2'h1, 6'h10);
        halt <= 1'b1;
        m(4, 32'h4001e7, 64'h000000ab_00001238, 2'h1, 6'h00);
        halt <= 1'b0;
        wide <= 1'b1;
        host.wr(8'h14, 64'h7001e7);
        m(0, 32'h1401e7, 64'h1000, 2'h1, 6'h01);
        ctx1 <= 32'h0;
        m(0, 32'h1401e7, 64'h1000, 2'h1, 6'h00);
    endtask : t_ctx
    task automatic stop_test;
        if (err_total == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        t_regs;
        t_mask;
        t_addr;
        t_ctx;
        stop_test;
    end
    initial
    begin
        repeat (5000) @(posedge clock);
        err_total++;
        stop_test;
    end
endmodule : bpm_top_test
`default_nettype wire
